/* tscr_map.svh */
`ifndef TSCR_MAP_SVH
`define TSCR_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define TSCR_OFS_CTRL_STATUS 5'h00
`define TSCR_OFS_MODE 5'h04
`define TSCR_OFS_COMPARE 5'h08
`define TSCR_OFS_COUNTER 5'h0c
`define TSCR_OFS_IRQ_REQ 5'h10
`define TSCR_OFS_IRQ_EN 5'h14

// Field positions inside timer_ctrl_status.
`define TSCR_BIT_HIGH_OVF_FLAG 7
`define TSCR_BIT_HIGH_MATCH_FLAG 6
`define TSCR_BIT_HIGH_OVF_IRQ_EN 5
`define TSCR_BIT_HIGH_CLR_ON_MATCH 4
`define TSCR_BIT_LOW_OVF_FLAG 3
`define TSCR_BIT_LOW_MATCH_FLAG 2
`define TSCR_BIT_LOW_OVF_IRQ_EN 1
`define TSCR_BIT_LOW_CLR_ON_MATCH 0

// Field positions inside the mode, request and enable registers.
`define TSCR_BIT_SPLIT_MODE 0
`define TSCR_BIT_IRQ_HIGH 0
`define TSCR_BIT_IRQ_LOW 1

// Reset values.
`define TSCR_RST_CTRL_STATUS 8'h00
`define TSCR_RST_COMPARE 16'hffff
`define TSCR_RST_COUNTER 16'h0000
`define TSCR_RST_IRQ 2'h0

// AXI responses.
`define TSCR_RESP_OKAY 2'h0
`define TSCR_RESP_SLVERR 2'h2

`endif

/* tscr_pkg.sv */
package tscr_pkg;

   // Events raised by the counter in one cycle.
   typedef struct packed {
      logic high_ovf;
      logic high_match;
      logic low_ovf;
      logic low_match;
   } tscr_evt_type;

   // Byte-wise software write into the 16-bit counter value.
   typedef struct packed {
      logic [1:0] be;
      logic [15:0] data;
   } tscr_wr_type;

endpackage : tscr_pkg

/* tscr_flag_bank.sv */
`timescale 1ns/1ns

// Sticky flags that software clears by writing 0 after having read them as 1.
module tscr_flag_bank #(
   parameter int W = 4
) (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [W-1:0] set_evt, // Hardware set strobes.
   input wire logic rd_stb, // Register read strobe.
   input wire logic wr_stb, // Register write strobe.
   input wire logic [W-1:0] wr_bits, // Written flag values.
   output logic [W-1:0] flags // Current flag values.
);

   logic [W-1:0] flags_r;
   logic [W-1:0] arm_r;
   logic [W-1:0] arm_nxt;
   logic [W-1:0] clr;
   logic [W-1:0] flags_nxt;

   // A read arms each flag that it saw as 1; a write disarms, but a read in the same cycle wins.
   assign arm_nxt = rd_stb ? flags_r : (wr_stb ? '0 : arm_r);
   // Only a 0 written to an armed flag clears; a 1 changes nothing.
   assign clr = {W{wr_stb}} & ~wr_bits & arm_r;
   // Set wins over a clear in the same cycle.
   assign flags_nxt = set_evt | (flags_r & ~clr);
   assign flags = flags_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flags_r <= '0;
         arm_r <= '0;
      end
      else
      begin
         flags_r <= flags_nxt;
         arm_r <= arm_nxt;
      end
   end

endmodule : tscr_flag_bank

/* tscr_counter.sv */
`timescale 1ns/1ns
`include "tscr_map.svh"

// 16-bit up-counter, or two independent 8-bit counters in split mode.
module tscr_counter (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic split, // 1 selects two 8-bit counters.
   input wire logic tick_high, // High half count strobe, split mode.
   input wire logic tick_low, // Low half or 16-bit count strobe.
   input wire logic [15:0] compare, // Compare value.
   input wire logic [1:0] cmp_wr, // Compare bytes written this cycle.
   input wire logic clr_high, // Clear on high or 16-bit match.
   input wire logic clr_low, // Clear low half on low match, split mode.
   input wire tscr_pkg::tscr_wr_type cnt_wr, // Software counter write.
   output logic [15:0] count, // Counter value.
   output tscr_pkg::tscr_evt_type evt // Events this cycle.
);

   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] cnt_cnt;
   logic [7:0] lo_inc;
   logic [7:0] hi_inc;
   logic lo_match;
   logic hi_match;
   logic wide_match;
   logic lo_wrap;
   logic hi_wrap;
   logic wide_wrap;

   // A match event fires as the counter leaves the matching value.
   assign lo_match = tick_low & (cnt_r[7:0] == compare[7:0]) & ~cmp_wr[0];
   assign hi_match = tick_high & (cnt_r[15:8] == compare[15:8]) & ~cmp_wr[1];
   assign wide_match = tick_low & (cnt_r == compare) & ~(|cmp_wr);
   assign lo_wrap = tick_low & (cnt_r[7:0] == 8'hff) & ~cnt_wr.be[0];
   assign hi_wrap = tick_high & (cnt_r[15:8] == 8'hff) & ~cnt_wr.be[1];
   assign wide_wrap = tick_low & (cnt_r == 16'hffff) & ~(|cnt_wr.be);

   assign lo_inc = (lo_match & clr_low) ? 8'h00 : cnt_r[7:0] + 8'h01;
   assign hi_inc = (hi_match & clr_high) ? 8'h00 : cnt_r[15:8] + 8'h01;

   always_comb
   begin
      cnt_cnt = cnt_r;
      if (split)
      begin
         if (tick_low)
            cnt_cnt[7:0] = lo_inc;
         if (tick_high)
            cnt_cnt[15:8] = hi_inc;
      end
      else if (tick_low)
      begin
         if (wide_match & clr_high)
            cnt_cnt = 16'h0000;
         else
            cnt_cnt = cnt_r + 16'h0001;
      end
      cnt_nxt = cnt_cnt;
      if (cnt_wr.be[0])
         cnt_nxt[7:0] = cnt_wr.data[7:0];
      if (cnt_wr.be[1])
         cnt_nxt[15:8] = cnt_wr.data[15:8];
   end

   assign evt.high_ovf = split ? hi_wrap : wide_wrap;
   assign evt.high_match = split ? hi_match : wide_match;
   assign evt.low_ovf = lo_wrap;
   assign evt.low_match = lo_match;
   assign count = cnt_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_r <= `TSCR_RST_COUNTER;
      else
         cnt_r <= cnt_nxt;
   end

endmodule : tscr_counter

/* tscr_top.sv */
`timescale 1ns/1ns
`include "tscr_map.svh"

// Behaviour
// - High overflow sets high overflow flag
// - High overflow flag clears by read-1-then-write-0
// - High compare match sets high match flag
// - High match flag clears by read-then-write-0
// - Enable bit gates high overflow interrupt request
// - 16-bit mode: match clears whole counter
// - Split mode: match clears high counter only
// - Low overflow sets low overflow flag
// - Low overflow flag clears by read-then-write-0
// - Low compare match sets low match flag
// - Low match flag clears by read-then-write-0
// - Enable bit gates low overflow interrupt request
// - Split mode: low match clears low counter when enabled
// - Writing 1 to flags changes nothing
// - Split select picks 16-bit or 8-bit mode
// - 16-bit wrap sets high overflow flag
// - Enabled overflow raises interrupt request flag
module tscr_top #(
   parameter int ADDR_W = 5
) (
   input wire logic aclk, // System clock, 20 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic tick_high, // High half count strobe.
   input wire logic tick_low, // Low half count strobe.
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   output logic irq // Interrupt, high while an enabled request is set.
);

   // Write channel holding registers.
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_fire;
   logic w_fire;
   logic do_write;
   logic aw_have_nxt;
   logic w_have_nxt;
   logic bvalid_nxt;

   // Read channel registers.
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic ar_fire;
   logic rvalid_nxt;

   // Block state.
   logic [3:0] enables_r;
   logic split_r;
   logic [15:0] compare_r;
   logic [1:0] irq_req_r;
   logic [1:0] irq_en_r;
   logic irq_r;
   logic [3:0] flags;
   logic [15:0] count;
   tscr_pkg::tscr_evt_type evt;
   tscr_pkg::tscr_wr_type cnt_wr;

   // Decode.
   logic wsel_cs;
   logic wsel_mode;
   logic wsel_cmp;
   logic wsel_cnt;
   logic wsel_ien;
   logic wsel_ok;
   logic rsel_cs;
   logic rsel_req;
   logic rsel_ok;
   logic [31:0] rd_mux;
   logic [7:0] cs_value;
   logic [1:0] cmp_wr;
   logic [1:0] req_set;
   logic [1:0] req_nxt;
   logic [15:0] compare_nxt;
   logic cs_wr;
   logic mode_wr;
   logic ien_wr;
   logic cs_rd;
   logic req_rd;

   // Packs the four flags and four control bits into the status layout.
   function automatic logic [7:0] cs_pack(input logic [3:0] f, input logic [3:0] e);
      logic [7:0] v;
      v = 8'h00;
      v[`TSCR_BIT_HIGH_OVF_FLAG] = f[3];
      v[`TSCR_BIT_HIGH_MATCH_FLAG] = f[2];
      v[`TSCR_BIT_LOW_OVF_FLAG] = f[1];
      v[`TSCR_BIT_LOW_MATCH_FLAG] = f[0];
      v[`TSCR_BIT_HIGH_OVF_IRQ_EN] = e[3];
      v[`TSCR_BIT_HIGH_CLR_ON_MATCH] = e[2];
      v[`TSCR_BIT_LOW_OVF_IRQ_EN] = e[1];
      v[`TSCR_BIT_LOW_CLR_ON_MATCH] = e[0];
      return v;
   endfunction : cs_pack

   // Byte-lane merge of a 16-bit register with written data.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [1:0] be);
      logic [15:0] v;
      v = old;
      if (be[0])
         v[7:0] = d[7:0];
      if (be[1])
         v[15:8] = d[15:8];
      return v;
   endfunction : merge16

   // Write channel: address and data taken in either order.
   assign aw_fire = s_axi_awvalid & awready_r;
   assign w_fire = s_axi_wvalid & wready_r;
   assign do_write = aw_have_r & w_have_r & ~bvalid_r;
   assign aw_have_nxt = aw_fire | (aw_have_r & ~do_write);
   assign w_have_nxt = w_fire | (w_have_r & ~do_write);
   assign bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);

   // Any offset that is not a register word answers with a slave error.
   assign wsel_cs = aw_addr_r == `TSCR_OFS_CTRL_STATUS;
   assign wsel_mode = aw_addr_r == `TSCR_OFS_MODE;
   assign wsel_cmp = aw_addr_r == `TSCR_OFS_COMPARE;
   assign wsel_cnt = aw_addr_r == `TSCR_OFS_COUNTER;
   assign wsel_ien = aw_addr_r == `TSCR_OFS_IRQ_EN;
   assign wsel_ok = wsel_cs | wsel_mode | wsel_cmp | wsel_cnt | wsel_ien
                    | (aw_addr_r == `TSCR_OFS_IRQ_REQ);

   // Read channel: one read at a time, answered the cycle after it is taken.
   assign ar_fire = s_axi_arvalid & arready_r;
   assign rvalid_nxt = ar_fire | (rvalid_r & ~s_axi_rready);
   assign rsel_cs = s_axi_araddr == `TSCR_OFS_CTRL_STATUS;
   assign rsel_req = s_axi_araddr == `TSCR_OFS_IRQ_REQ;
   assign rsel_ok = rsel_cs | rsel_req | (s_axi_araddr == `TSCR_OFS_MODE)
                    | (s_axi_araddr == `TSCR_OFS_COMPARE) | (s_axi_araddr == `TSCR_OFS_COUNTER)
                    | (s_axi_araddr == `TSCR_OFS_IRQ_EN);

   assign cs_value = cs_pack(flags, enables_r);
   assign rd_mux = rsel_cs ? {24'h000000, cs_value} :
                   (s_axi_araddr == `TSCR_OFS_MODE) ? {31'h00000000, split_r} :
                   (s_axi_araddr == `TSCR_OFS_COMPARE) ? {16'h0000, compare_r} :
                   (s_axi_araddr == `TSCR_OFS_COUNTER) ? {16'h0000, count} :
                   rsel_req ? {30'h00000000, irq_req_r} :
                   (s_axi_araddr == `TSCR_OFS_IRQ_EN) ? {30'h00000000, irq_en_r} :
                   32'h00000000;

   // Software writes to the counter and compare value.
   assign cnt_wr.be = w_strb_r[1:0] & {2{do_write & wsel_cnt}};
   assign cnt_wr.data = w_data_r[15:0];
   assign cmp_wr = w_strb_r[1:0] & {2{do_write & wsel_cmp}};
   assign compare_nxt = merge16(compare_r, w_data_r, cmp_wr);

   // Register strobes on the cycle a write lands or a read is taken.
   assign cs_wr = do_write & wsel_cs & w_strb_r[0];
   assign mode_wr = do_write & wsel_mode & w_strb_r[0];
   assign ien_wr = do_write & wsel_ien & w_strb_r[0];
   assign cs_rd = ar_fire & rsel_cs;
   assign req_rd = ar_fire & rsel_req;

   // Interrupt requests: overflow only when its enable is set, match always.
   assign req_set[`TSCR_BIT_IRQ_HIGH] = (evt.high_ovf & enables_r[3]) | evt.high_match;
   assign req_set[`TSCR_BIT_IRQ_LOW] = (evt.low_ovf & enables_r[1]) | evt.low_match;
   // Reading the request register clears it, but a new request wins.
   assign req_nxt = req_set | (irq_req_r & ~{2{req_rd}});

   tscr_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .split(split_r),
      .tick_high(tick_high),
      .tick_low(tick_low),
      .compare(compare_r),
      .cmp_wr(cmp_wr),
      .clr_high(enables_r[2]),
      .clr_low(enables_r[0]),
      .cnt_wr(cnt_wr),
      .count(count),
      .evt(evt)
   );

   tscr_flag_bank #(
      .W(4)
   ) u_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_evt({evt.high_ovf, evt.high_match, evt.low_ovf, evt.low_match}),
      .rd_stb(cs_rd),
      .wr_stb(cs_wr),
      .wr_bits({w_data_r[`TSCR_BIT_HIGH_OVF_FLAG], w_data_r[`TSCR_BIT_HIGH_MATCH_FLAG],
                w_data_r[`TSCR_BIT_LOW_OVF_FLAG], w_data_r[`TSCR_BIT_LOW_MATCH_FLAG]}),
      .flags(flags)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `TSCR_RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end
      else
      begin
         awready_r <= ~aw_have_nxt & ~bvalid_nxt;
         wready_r <= ~w_have_nxt & ~bvalid_nxt;
         bvalid_r <= bvalid_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         if (do_write)
            bresp_r <= wsel_ok ? `TSCR_RESP_OKAY : `TSCR_RESP_SLVERR;
         if (aw_fire)
            aw_addr_r <= s_axi_awaddr;
         if (w_fire)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `TSCR_RESP_OKAY;
      end
      else
      begin
         arready_r <= ~rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (ar_fire)
         begin
            rdata_r <= rd_mux;
            rresp_r <= rsel_ok ? `TSCR_RESP_OKAY : `TSCR_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enables_r <= 4'h0;
         split_r <= 1'b0;
         compare_r <= `TSCR_RST_COMPARE;
         irq_req_r <= `TSCR_RST_IRQ;
         irq_en_r <= `TSCR_RST_IRQ;
         irq_r <= 1'b0;
      end
      else
      begin
         if (cs_wr)
            enables_r <= {w_data_r[`TSCR_BIT_HIGH_OVF_IRQ_EN], w_data_r[`TSCR_BIT_HIGH_CLR_ON_MATCH],
                          w_data_r[`TSCR_BIT_LOW_OVF_IRQ_EN], w_data_r[`TSCR_BIT_LOW_CLR_ON_MATCH]};
         if (mode_wr)
            split_r <= w_data_r[`TSCR_BIT_SPLIT_MODE];
         if (ien_wr)
            irq_en_r <= w_data_r[1:0];
         compare_r <= compare_nxt;
         irq_req_r <= req_nxt;
         irq_r <= |(req_nxt & irq_en_r);
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign irq = irq_r;

endmodule : tscr_top

/* tscr_top_chk.sv */
`timescale 1ns/1ns
`include "tscr_map.svh"

// Watches the register bus and the interrupt pin of the timer control block.
module tscr_top_chk #(
   parameter int ADDR_W = 5
) (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset.
   input wire logic s_axi_awvalid, // AW valid.
   input wire logic s_axi_awready, // AW ready.
   input wire logic s_axi_wvalid, // W valid.
   input wire logic s_axi_wready, // W ready.
   input wire logic [1:0] s_axi_bresp, // B resp.
   input wire logic s_axi_bvalid, // B valid.
   input wire logic s_axi_bready, // B ready.
   input wire logic [ADDR_W-1:0] s_axi_araddr, // AR addr.
   input wire logic s_axi_arvalid, // AR valid.
   input wire logic s_axi_arready, // AR ready.
   input wire logic [31:0] s_axi_rdata, // R data.
   input wire logic [1:0] s_axi_rresp, // R resp.
   input wire logic s_axi_rvalid, // R valid.
   input wire logic s_axi_rready, // R ready.
   input wire logic irq // Interrupt.
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer not two cycles after handshake");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
      && (s_axi_araddr > `TSCR_OFS_IRQ_EN || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == `TSCR_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_read: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr <= `TSCR_OFS_IRQ_EN && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rresp == `TSCR_RESP_OKAY)
      else $error("mapped read refused");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_arready && !s_axi_awready && !irq)
      else $error("outputs active right after reset");
endmodule : tscr_top_chk

bind tscr_top tscr_top_chk #(.ADDR_W(ADDR_W)) chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

/* testbench.sv */
`timescale 1ns/1ns
`include "tscr_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic tick_high, tick_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_total = 0;
   int tests_run = 0;
   int m_cnt, m_cmp, rnd;
   logic [7:0] m_ctrl, m_arm;
   logic [1:0] m_req, m_ien;
   logic m_split;

   always #25 aclk = ~aclk;

   tscr_top #(.ADDR_W(5)) dut_u (.aclk(aclk), .aresetn(aresetn), .tick_high(tick_high),
      .tick_low(tick_low), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .irq(irq));

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   task automatic tmo(input int n);
      if (n >= 100)
      begin
         err_total++;
         test_done();
      end
   endtask : tmo

   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid || s_axi_wvalid) && n < 100);
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      tmo(n);
      `CHK(s_axi_bresp, (a > `TSCR_OFS_IRQ_EN || a[1:0] != 2'h0) ? 2'h2 : 2'h0)
   endtask : bus_wr

   task automatic reg_wr(input logic [4:0] a, input int d);
      bus_wr(a, d);
      case (a)
         `TSCR_OFS_CTRL_STATUS:
         begin
            m_ctrl = (m_ctrl & 8'hcc & ~(m_arm & ~d[7:0])) | (d[7:0] & 8'h33);
            m_arm = 8'h00;
         end
         `TSCR_OFS_MODE: m_split = d[0];
         `TSCR_OFS_COMPARE: m_cmp = d & 32'hffff;
         `TSCR_OFS_COUNTER: m_cnt = d & 32'hffff;
         `TSCR_OFS_IRQ_EN: m_ien = d[1:0];
         default: ;
      endcase
   endtask : reg_wr

   task automatic reg_rd(input logic [4:0] a);
      logic [31:0] e;
      int n;
      case (a)
         `TSCR_OFS_CTRL_STATUS: e = {24'h0, m_ctrl};
         `TSCR_OFS_MODE: e = {31'h0, m_split};
         `TSCR_OFS_COMPARE: e = m_cmp;
         `TSCR_OFS_COUNTER: e = m_cnt;
         `TSCR_OFS_IRQ_REQ: e = {30'h0, m_req};
         `TSCR_OFS_IRQ_EN: e = {30'h0, m_ien};
         default: e = 32'h0;
      endcase
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      tmo(n);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, (a > `TSCR_OFS_IRQ_EN || a[1:0] != 2'h0) ? 2'h2 : 2'h0)
      if (a == `TSCR_OFS_CTRL_STATUS)
         m_arm = m_ctrl & 8'hcc;
      if (a == `TSCR_OFS_IRQ_REQ)
         m_req = 2'h0;
   endtask : reg_rd

   function automatic void ev(input int fb, input int rb, input bit rq);
      m_ctrl[fb] = 1'b1;
      if (rq)
         m_req[rb] = 1'b1;
   endfunction : ev

   // One 8-bit half; hb selects the field group of that half in the status byte.
   function automatic int step(input int v, input int c, input int hb);
      if (v == c)
         ev(hb + 2, hb == 0, 1'b1);
      if (v == 255)
         ev(hb + 3, hb == 0, m_ctrl[hb + 1]);
      if (v == c && m_ctrl[hb])
         return 0;
      return (v + 1) & 255;
   endfunction : step

   task automatic mtick(input bit h, input bit l);
      int lo, hi;
      lo = m_cnt & 255;
      hi = m_cnt >> 8;
      if (m_split)
      begin
         if (l)
            lo = step(lo, m_cmp & 255, 0);
         if (h)
            hi = step(hi, m_cmp >> 8, 4);
         m_cnt = hi * 256 + lo;
      end
      else if (l)
      begin
         if (lo == (m_cmp & 255))
            ev(2, 1, 1'b1);
         if (lo == 255)
            ev(3, 1, m_ctrl[1]);
         if (m_cnt == m_cmp)
            ev(6, 0, 1'b1);
         if (m_cnt == 65535)
            ev(7, 0, m_ctrl[5]);
         m_cnt = (m_cnt == m_cmp && m_ctrl[4]) ? 0 : (m_cnt + 1) & 65535;
      end
   endtask : mtick

   task automatic ticks(input int n, input bit rnd_on);
      bit h, l;
      repeat (n)
      begin
         h = rnd_on & m_split & $urandom_range(1);
         l = rnd_on ? $urandom_range(1) : 1'b1;
         tick_high <= h;
         tick_low <= l;
         mtick(h, l);
         @(posedge aclk);
      end
      tick_high <= 1'b0;
      tick_low <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK(irq, |(m_req & m_ien))
   endtask : ticks

   initial
   begin
      {tick_high, tick_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      rnd = $urandom(94);
      {m_cnt, m_cmp, m_ctrl, m_arm, m_req, m_ien, m_split} = {32'h0, 32'hffff, 21'h0};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 7; i++)
         reg_rd(5'(i * 4));
      reg_wr(5'h18, 32'hff);
      reg_rd(5'h06);
      reg_wr(`TSCR_OFS_COMPARE, 32'h1234);
      reg_wr(`TSCR_OFS_COUNTER, 32'hfffe);
      ticks(2, 1'b0);
      reg_wr(`TSCR_OFS_CTRL_STATUS, 32'h22);
      reg_rd(`TSCR_OFS_CTRL_STATUS);
      reg_wr(`TSCR_OFS_CTRL_STATUS, 32'hff);
      reg_rd(`TSCR_OFS_CTRL_STATUS);
      reg_wr(`TSCR_OFS_CTRL_STATUS, 32'h22);
      reg_rd(`TSCR_OFS_CTRL_STATUS);
      reg_wr(`TSCR_OFS_IRQ_EN, 32'h3);
      reg_wr(`TSCR_OFS_COUNTER, 32'hffff);
      ticks(1, 1'b0);
      reg_rd(`TSCR_OFS_IRQ_REQ);
      ticks(0, 1'b0);
      reg_wr(`TSCR_OFS_CTRL_STATUS, 32'h10);
      reg_wr(`TSCR_OFS_COMPARE, 32'h0105);
      reg_wr(`TSCR_OFS_COUNTER, 32'h0100);
      ticks(9, 1'b0);
      reg_rd(`TSCR_OFS_COUNTER);
      reg_rd(`TSCR_OFS_CTRL_STATUS);
      reg_wr(`TSCR_OFS_MODE, 32'h1);
      repeat (8)
      begin
         reg_wr(`TSCR_OFS_COMPARE, $urandom_range(255) * 256 + $urandom_range(255));
         reg_wr(`TSCR_OFS_COUNTER, $urandom_range(65535));
         reg_wr(`TSCR_OFS_CTRL_STATUS, ($urandom & 32'h33) | 32'hcc);
         reg_wr(`TSCR_OFS_IRQ_EN, $urandom_range(3));
         ticks(300, 1'b1);
         reg_rd(`TSCR_OFS_COUNTER);
         reg_rd(`TSCR_OFS_IRQ_REQ);
         reg_rd(`TSCR_OFS_CTRL_STATUS);
         reg_wr(`TSCR_OFS_CTRL_STATUS, {24'h0, m_ctrl & 8'h33});
      end
      reg_rd(`TSCR_OFS_CTRL_STATUS);
      test_done();
   end
endmodule : testbench
